// ==== core/pps_pin_select.sv ====
// Pin function multiplexer for ports A and B with its APB register file.
// Functional notes
// - Enable bit 0 gives pin to port logic; 1 lets select field choose peripheral.
// - Shared function fans output to all its pins; input is OR of those pins.
// - Switching to a peripheral function passes through a disconnected cycle; the hardware inserts it, so no software delay is needed.
// - After reset every pin is under port control.
// - Port A pin 6: 0 fault input 0, 1 timer channel 0.
// - Port A pin 5: 00 PWM 5, 01 fault 2, 10 timer channel 3.
// - Port A pin 4: 00 PWM 4, 01 fault 1, 10 timer channel 2.
// - Port A pin 11: 0 comparator B input 2, 1 reserved.
// - Port A pin 10: 0 comparator A input 2, 1 reserved.
// - Port A pin 9: 00 fault 2, 01 timer 3, 10 comparator B input 1.
// - Port A pin 8: 00 fault 1, 01 timer 2, 10 comparator A input 1.
// - Port B pin 6: 00 serial receive, 01 I2C data, 10 external clock.
// - Port B pin 5: 00 timer 1, 01 fault 3, 10 external clock.
// - Port B pin 3: 00 SPI master out, 01 timer 3, 10 PWM pair 2/3 source.
// - Port B pin 2: 00 SPI master in, 01 timer 2, 10 PWM pair 0/1 source.
// - Port B pin 1: 0 SPI slave select, 1 I2C data.
// - Port B pin 0: 0 SPI serial clock, 1 I2C clock.
// - Port B pin 11: 0 comparator B output, 1 reserved.
// - Port B pin 10: 0 comparator A output, 1 reserved.
// - Port B pin 7: 0 serial transmit, 1 I2C clock.
// - Reserved register bits read zero and are written zero.
// - Protection 01 or 11 blocks select writes; 10 or 11 lock protection.
`timescale 1ns/100ps
`include "pps_cfg.svh"

module pps_pin_select (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] port_a_out,
	input  wire logic [15:0] port_a_drive,
	input  wire logic [15:0] port_b_out,
	input  wire logic [15:0] port_b_drive,
	output logic      [15:0] port_a_in,
	output logic      [15:0] port_b_in,
	input  wire logic [26:0] periph_out,
	input  wire logic [26:0] periph_drive,
	output logic      [26:0] periph_in,
	input  wire logic [15:0] pad_a_i,
	input  wire logic [15:0] pad_b_i,
	output logic      [15:0] pad_a_o,
	output logic      [15:0] pad_b_o,
	output logic      [15:0] pad_a_oe_n,
	output logic      [15:0] pad_b_oe_n
);

	// ============================================================
	// Registers
	logic [1:0]  prot_r;
	logic [15:0] gpsa0_r;
	logic [15:0] gpsa1_r;
	logic [15:0] gpsb0_r;
	logic [15:0] gpsb1_r;
	logic [15:0] peren_a_r;
	logic [15:0] peren_b_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] pad_s1_r;
	logic [31:0] pad_s2_r;
	logic [31:0] pad_o_r;
	logic [31:0] pad_oe_n_r;
	logic [31:0] port_in_r;
	logic [26:0] periph_in_r;
	logic [26:0] periph_in_nxt;
	pps_pkg::pps_func_t cur_r [`PPS_NUM_PINS];
	pps_pkg::pps_func_t want  [`PPS_NUM_PINS];

	// ============================================================
	// Field decoding
	function automatic logic [1:0] code_of(input int p, input logic [15:0] a0,
		input logic [15:0] a1, input logic [15:0] b0, input logic [15:0] b1);
		logic [1:0] c;
		c = 2'h3;
		case (p)
			4:  c = a0[`PPS_POS_A4 +: 2];
			5:  c = a0[`PPS_POS_A5 +: 2];
			6:  c = {1'b0, a0[`PPS_POS_A6]};
			8:  c = a1[`PPS_POS_A8 +: 2];
			9:  c = a1[`PPS_POS_A9 +: 2];
			10: c = {a1[`PPS_POS_A10], 1'b0};
			11: c = {a1[`PPS_POS_A11], 1'b0};
			16: c = {1'b0, b0[`PPS_POS_B0]};
			17: c = {1'b0, b0[`PPS_POS_B1]};
			18: c = b0[`PPS_POS_B2 +: 2];
			19: c = b0[`PPS_POS_B3 +: 2];
			21: c = b0[`PPS_POS_B5 +: 2];
			22: c = b0[`PPS_POS_B6 +: 2];
			23: c = {1'b0, b1[`PPS_POS_B7]};
			26: c = {b1[`PPS_POS_B10], 1'b0};
			27: c = {b1[`PPS_POS_B11], 1'b0};
			default: c = 2'h3;
		endcase
		return c;
	endfunction

	// Single-bit fields with a reserved 1 are shifted to code 2 so that 1 stays a real choice.
	function automatic pps_pkg::pps_func_t fn_of(input int p, input logic [1:0] c);
		pps_pkg::pps_func_t f;
		f = pps_pkg::PPS_NONE;
		case (p)
			4:  f = (c == 2'h0) ? pps_pkg::PPS_PWM_OUTPUT_FOUR : (c == 2'h1) ? pps_pkg::PPS_PWM_FAULT_IN_ONE :
				(c == 2'h2) ? pps_pkg::PPS_TMR2 : pps_pkg::PPS_NONE;
			5:  f = (c == 2'h0) ? pps_pkg::PPS_PWM_OUTPUT_FIVE : (c == 2'h1) ? pps_pkg::PPS_PWM_FAULT_IN_TWO :
				(c == 2'h2) ? pps_pkg::PPS_TMR3 : pps_pkg::PPS_NONE;
			6:  f = (c == 2'h0) ? pps_pkg::PPS_PWM_FAULT_IN_ZERO : pps_pkg::PPS_TMR0;
			8:  f = (c == 2'h0) ? pps_pkg::PPS_PWM_FAULT_IN_ONE : (c == 2'h1) ? pps_pkg::PPS_TMR2 :
				(c == 2'h2) ? pps_pkg::PPS_COMPARATOR_A_IN_ONE : pps_pkg::PPS_NONE;
			9:  f = (c == 2'h0) ? pps_pkg::PPS_PWM_FAULT_IN_TWO : (c == 2'h1) ? pps_pkg::PPS_TMR3 :
				(c == 2'h2) ? pps_pkg::PPS_COMPARATOR_B_IN_ONE : pps_pkg::PPS_NONE;
			10: f = (c == 2'h0) ? pps_pkg::PPS_CMPAI2 : pps_pkg::PPS_NONE;
			11: f = (c == 2'h0) ? pps_pkg::PPS_CMPBI2 : pps_pkg::PPS_NONE;
			16: f = (c == 2'h0) ? pps_pkg::PPS_SCLK : pps_pkg::PPS_SCL;
			17: f = (c == 2'h0) ? pps_pkg::PPS_SSEL : pps_pkg::PPS_SDA;
			18: f = (c == 2'h0) ? pps_pkg::PPS_MISO : (c == 2'h1) ? pps_pkg::PPS_TMR2 :
				(c == 2'h2) ? pps_pkg::PPS_PWM_PAIR_ZERO_SOURCE : pps_pkg::PPS_NONE;
			19: f = (c == 2'h0) ? pps_pkg::PPS_MOSI : (c == 2'h1) ? pps_pkg::PPS_TMR3 :
				(c == 2'h2) ? pps_pkg::PPS_PWM_PAIR_ONE_SOURCE : pps_pkg::PPS_NONE;
			21: f = (c == 2'h0) ? pps_pkg::PPS_TMR1 : (c == 2'h1) ? pps_pkg::PPS_PWM_FAULT_IN_THREE :
				(c == 2'h2) ? pps_pkg::PPS_XCLK : pps_pkg::PPS_NONE;
			22: f = (c == 2'h0) ? pps_pkg::PPS_SRX : (c == 2'h1) ? pps_pkg::PPS_SDA :
				(c == 2'h2) ? pps_pkg::PPS_XCLK : pps_pkg::PPS_NONE;
			23: f = (c == 2'h0) ? pps_pkg::PPS_STX : pps_pkg::PPS_SCL;
			26: f = (c == 2'h0) ? pps_pkg::PPS_COMPARATOR_A_OUTPUT : pps_pkg::PPS_NONE;
			27: f = (c == 2'h0) ? pps_pkg::PPS_COMPARATOR_B_OUTPUT : pps_pkg::PPS_NONE;
			default: f = pps_pkg::PPS_NONE;
		endcase
		return f;
	endfunction

	function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
		return (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	// Plain table lookup for the assertions, kept apart from the shifted codes of fn_of.
	function automatic pps_pkg::pps_func_t pick(input logic [1:0] c, input pps_pkg::pps_func_t x,
		input pps_pkg::pps_func_t y, input pps_pkg::pps_func_t z);
		return (c == 2'h0) ? x : (c == 2'h1) ? y : (c == 2'h2) ? z : pps_pkg::PPS_NONE;
	endfunction

	// ============================================================
	// APB decode
	wire        wr_go    = psel & penable & pready_r & pwrite;
	wire        hit_prot = idx_hit(paddr, `PPS_IDX_PROT);
	wire        hit_a0   = idx_hit(paddr, `PPS_IDX_GPSA0);
	wire        hit_a1   = idx_hit(paddr, `PPS_IDX_GPSA1);
	wire        hit_b0   = idx_hit(paddr, `PPS_IDX_GPSB0);
	wire        hit_b1   = idx_hit(paddr, `PPS_IDX_GPSB1);
	wire        hit_cd   = idx_hit(paddr, `PPS_IDX_GPSCD);
	wire        hit_pa   = idx_hit(paddr, `PPS_IDX_PEREN_A);
	wire        hit_pb   = idx_hit(paddr, `PPS_IDX_PEREN_B);
	wire        hit_any  = hit_prot | hit_a0 | hit_a1 | hit_b0 | hit_b1 | hit_cd | hit_pa | hit_pb;
	wire        sel_open = ~prot_r[`PPS_PROT_ON];
	wire        prot_open = ~prot_r[`PPS_PROT_LOCK];
	wire [15:0] wd       = pwdata[15:0];
	wire [15:0] rd_val   = hit_prot ? {14'h0000, prot_r} :
		hit_a0 ? gpsa0_r : hit_a1 ? gpsa1_r : hit_b0 ? gpsb0_r : hit_b1 ? gpsb1_r :
		hit_pa ? peren_a_r : hit_pb ? peren_b_r : 16'h0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel & ~penable;
			prdata_r  <= {16'h0000, rd_val};
			pslverr_r <= psel & ~penable & ~hit_any;
		end
	end

	// Writes to protected select or enable registers are dropped without an error response.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_r    <= 2'h0;
			gpsa0_r   <= `PPS_RST_VALUE;
			gpsa1_r   <= `PPS_RST_VALUE;
			gpsb0_r   <= `PPS_RST_VALUE;
			gpsb1_r   <= `PPS_RST_VALUE;
			peren_a_r <= `PPS_RST_VALUE;
			peren_b_r <= `PPS_RST_VALUE;
		end else begin
			if (wr_go && hit_prot && prot_open)
				prot_r <= wd[1:0];
			if (wr_go && hit_a0 && sel_open)
				gpsa0_r <= wd & `PPS_MASK_GPSA0;
			if (wr_go && hit_a1 && sel_open)
				gpsa1_r <= wd & `PPS_MASK_GPSA1;
			if (wr_go && hit_b0 && sel_open)
				gpsb0_r <= wd & `PPS_MASK_GPSB0;
			if (wr_go && hit_b1 && sel_open)
				gpsb1_r <= wd & `PPS_MASK_GPSB1;
			if (wr_go && hit_pa && sel_open)
				peren_a_r <= wd & `PPS_MASK_PEREN;
			if (wr_go && hit_pb && sel_open)
				peren_b_r <= wd & `PPS_MASK_PEREN;
		end
	end

	// ============================================================
	// Pin routing
	wire [31:0] peren    = {peren_b_r, peren_a_r};
	wire [31:0] port_out = {port_b_out, port_a_out};
	wire [31:0] port_drv = {port_b_drive, port_a_drive};

	for (genvar p = 0; p < `PPS_NUM_PINS; p++) begin : g_pin
		assign want[p] = peren[p] ? fn_of(p, code_of(p, gpsa0_r, gpsa1_r, gpsb0_r, gpsb1_r)) :
			pps_pkg::PPS_NONE;

		// A change between two peripherals always passes one cycle with the pin released,
		// so two drivers never fight on the pad during a switch.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				cur_r[p] <= pps_pkg::PPS_NONE;
			else if (cur_r[p] != want[p])
				cur_r[p] <= (cur_r[p] == pps_pkg::PPS_NONE) ? want[p] : pps_pkg::PPS_NONE;
		end

		wire       is_port = ~peren[p] && (cur_r[p] == pps_pkg::PPS_NONE);
		wire       is_per  = cur_r[p] != pps_pkg::PPS_NONE;
		wire [4:0] fi      = cur_r[p];
		wire       o_nxt   = is_port ? port_out[p] :
			(is_per && fi < 5'h1B) ? periph_out[fi] : 1'b0;
		wire       d_nxt   = is_port ? port_drv[p] :
			(is_per && fi < 5'h1B) ? periph_drive[fi] : 1'b0;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pad_o_r[p]    <= 1'b0;
				pad_oe_n_r[p] <= 1'b1;
			end else begin
				pad_o_r[p]    <= o_nxt;
				pad_oe_n_r[p] <= ~d_nxt;
			end
		end
	end

	// Pads are asynchronous to pclk; only the second stage feeds any logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_s1_r <= 32'h0000_0000;
			pad_s2_r <= 32'h0000_0000;
		end else begin
			pad_s1_r <= {pad_b_i, pad_a_i};
			pad_s2_r <= pad_s1_r;
		end
	end

	// Several pins on one function merge by OR; a single configured pin passes through.
	always_comb begin
		periph_in_nxt = 27'h0000000;
		for (int p = 0; p < `PPS_NUM_PINS; p++) begin
			for (int f = 0; f < `PPS_NUM_FUNC; f++) begin
				if (cur_r[p] == pps_pkg::pps_func_t'(f[4:0]) && pad_s2_r[p])
					periph_in_nxt[f] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_in_r <= 27'h0000000;
			port_in_r   <= 32'h0000_0000;
		end else begin
			periph_in_r <= periph_in_nxt;
			port_in_r   <= pad_s2_r;
		end
	end

	// ============================================================
	// Outputs
	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign pad_a_o    = pad_o_r[15:0];
	assign pad_b_o    = pad_o_r[31:16];
	assign pad_a_oe_n = pad_oe_n_r[15:0];
	assign pad_b_oe_n = pad_oe_n_r[31:16];
	assign port_a_in  = port_in_r[15:0];
	assign port_b_in  = port_in_r[31:16];
	assign periph_in  = periph_in_r;

	// ============================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// The release edge still loads reset values into the pads, so it starts no check here.
	port_owns_pin_a: assert property (presetn && !peren_a_r[4]
		&& cur_r[4] == pps_pkg::PPS_NONE
		|=> pad_a_o[4] == $past(port_a_out[4]) && pad_a_oe_n[4] == !$past(port_a_drive[4]))
		else $error("port logic does not own pin A4");
	fan_out_a: assert property (cur_r[5] == pps_pkg::PPS_TMR3
		&& cur_r[9] == pps_pkg::PPS_TMR3
		|=> pad_a_o[5] == pad_a_o[9] && pad_a_o[5] == $past(periph_out[7]))
		else $error("timer 3 output not fanned to both pins");
	input_merge_a: assert property (##1 periph_in[2] == $past(
		(cur_r[5] == pps_pkg::PPS_PWM_FAULT_IN_TWO && pad_s2_r[5]) ||
		(cur_r[9] == pps_pkg::PPS_PWM_FAULT_IN_TWO && pad_s2_r[9])))
		else $error("fault 2 input is not the OR of its pins");
	break_make_a: assert property ($past(cur_r[4]) != pps_pkg::PPS_NONE
		&& cur_r[4] != $past(cur_r[4]) |-> cur_r[4] == pps_pkg::PPS_NONE)
		else $error("pin A4 switched peripherals without a gap");
	reset_port_a: assert property (disable iff (1'b0) $rose(presetn)
		|-> peren_a_r == 16'h0000 && peren_b_r == 16'h0000 && pad_a_oe_n == 16'hFFFF)
		else $error("pins not under port control after reset");
	a6_route_a: assert property (peren_a_r[6] |-> want[6] == (gpsa0_r[12] ?
		pps_pkg::PPS_TMR0 : pps_pkg::PPS_PWM_FAULT_IN_ZERO))
		else $error("pin A6 select decodes wrongly");
	a5_route_a: assert property (peren_a_r[5] |-> want[5] == pick(gpsa0_r[11:10],
		pps_pkg::PPS_PWM_OUTPUT_FIVE, pps_pkg::PPS_PWM_FAULT_IN_TWO, pps_pkg::PPS_TMR3))
		else $error("pin A5 select decodes wrongly");
	a4_route_a: assert property (peren_a_r[4] |-> want[4] == pick(gpsa0_r[9:8],
		pps_pkg::PPS_PWM_OUTPUT_FOUR, pps_pkg::PPS_PWM_FAULT_IN_ONE, pps_pkg::PPS_TMR2))
		else $error("pin A4 select decodes wrongly");
	a11_route_a: assert property (peren_a_r[11] |-> want[11] == pick(
		{1'b0, gpsa1_r[6]}, pps_pkg::PPS_CMPBI2, pps_pkg::PPS_NONE, pps_pkg::PPS_NONE))
		else $error("pin A11 select decodes wrongly");
	a10_route_a: assert property (peren_a_r[10] |-> want[10] == pick(
		{1'b0, gpsa1_r[4]}, pps_pkg::PPS_CMPAI2, pps_pkg::PPS_NONE, pps_pkg::PPS_NONE))
		else $error("pin A10 select decodes wrongly");
	a9_route_a: assert property (peren_a_r[9] |-> want[9] == pick(gpsa1_r[3:2],
		pps_pkg::PPS_PWM_FAULT_IN_TWO, pps_pkg::PPS_TMR3, pps_pkg::PPS_COMPARATOR_B_IN_ONE))
		else $error("pin A9 select decodes wrongly");
	a8_route_a: assert property (peren_a_r[8] |-> want[8] == pick(gpsa1_r[1:0],
		pps_pkg::PPS_PWM_FAULT_IN_ONE, pps_pkg::PPS_TMR2, pps_pkg::PPS_COMPARATOR_A_IN_ONE))
		else $error("pin A8 select decodes wrongly");
	b6_route_a: assert property (peren_b_r[6] && gpsb0_r[14:13] == 2'h1
		|-> want[22] == pps_pkg::PPS_SDA)
		else $error("pin B6 select decodes wrongly");
	b5_route_a: assert property (peren_b_r[5] |-> want[21] == pick(gpsb0_r[12:11],
		pps_pkg::PPS_TMR1, pps_pkg::PPS_PWM_FAULT_IN_THREE, pps_pkg::PPS_XCLK))
		else $error("pin B5 select decodes wrongly");
	b3_route_a: assert property (peren_b_r[3] |-> want[19] == pick(gpsb0_r[7:6],
		pps_pkg::PPS_MOSI, pps_pkg::PPS_TMR3, pps_pkg::PPS_PWM_PAIR_ONE_SOURCE))
		else $error("pin B3 select decodes wrongly");
	b2_route_a: assert property (peren_b_r[2] |-> want[18] == pick(gpsb0_r[5:4],
		pps_pkg::PPS_MISO, pps_pkg::PPS_TMR2, pps_pkg::PPS_PWM_PAIR_ZERO_SOURCE))
		else $error("pin B2 select decodes wrongly");
	b1_route_a: assert property (peren_b_r[1] |-> want[17] == pick(
		{1'b0, gpsb0_r[2]}, pps_pkg::PPS_SSEL, pps_pkg::PPS_SDA, pps_pkg::PPS_NONE))
		else $error("pin B1 select decodes wrongly");
	b0_route_a: assert property (peren_b_r[0] |-> want[16] == pick(
		{1'b0, gpsb0_r[0]}, pps_pkg::PPS_SCLK, pps_pkg::PPS_SCL, pps_pkg::PPS_NONE))
		else $error("pin B0 select decodes wrongly");
	b11_route_a: assert property (peren_b_r[11] |-> want[27] == pick(
		{1'b0, gpsb1_r[8]}, pps_pkg::PPS_COMPARATOR_B_OUTPUT, pps_pkg::PPS_NONE, pps_pkg::PPS_NONE))
		else $error("pin B11 select decodes wrongly");
	b10_route_a: assert property (peren_b_r[10] |-> want[26] == pick(
		{1'b0, gpsb1_r[6]}, pps_pkg::PPS_COMPARATOR_A_OUTPUT, pps_pkg::PPS_NONE, pps_pkg::PPS_NONE))
		else $error("pin B10 select decodes wrongly");
	b7_route_a: assert property (peren_b_r[7] |-> want[23] == pick(
		{1'b0, gpsb1_r[0]}, pps_pkg::PPS_STX, pps_pkg::PPS_SCL, pps_pkg::PPS_NONE))
		else $error("pin B7 select decodes wrongly");
	reserved_zero_a: assert property (pready && psel && !pwrite
		|-> prdata[31:16] == 16'h0000 && (gpsb0_r & ~`PPS_MASK_GPSB0) == 16'h0000)
		else $error("reserved bits are not zero");
	sel_protect_a: assert property (prot_r[0] |=> $stable(gpsa0_r) && $stable(gpsb1_r)
		&& $stable(peren_a_r))
		else $error("select register changed while protected");
	prot_lock_a: assert property (prot_r[1] |=> $stable(prot_r))
		else $error("locked protection field changed");
	reserved_code_a: assert property (peren_a_r[5] && gpsa0_r[11:10] == 2'h3
		|-> want[5] == pps_pkg::PPS_NONE)
		else $error("reserved code on pin A5 selects a peripheral");

	write_cover_c: cover property (wr_go && hit_a0 && sel_open);
	blocked_cover_c: cover property (wr_go && hit_b0 && !sel_open);
	periph_cover_c: cover property (cur_r[22] == pps_pkg::PPS_SDA && !pad_b_oe_n[6]);
	fanout_cover_c: cover property (cur_r[5] == pps_pkg::PPS_TMR3
		&& cur_r[9] == pps_pkg::PPS_TMR3);
	lock_cover_c: cover property (prot_r == 2'h3);

endmodule

// ==== inc/pps_cfg.svh ====
// Register indices, field positions, masks and reset values of the pin function selector.
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// ============================================================
// Register word indices (byte address is four times the index)
`define PPS_IDX_PROT     8'h12
`define PPS_IDX_GPSA0    8'h13
`define PPS_IDX_GPSA1    8'h14
`define PPS_IDX_GPSB0    8'h15
`define PPS_IDX_GPSB1    8'h16
`define PPS_IDX_GPSCD    8'h17
`define PPS_IDX_PEREN_A  8'h20
`define PPS_IDX_PEREN_B  8'h21

// ============================================================
// Writable bit masks; every other bit reads as zero
`define PPS_MASK_PROT    16'h0003
`define PPS_MASK_GPSA0   16'h1F00
`define PPS_MASK_GPSA1   16'h005F
`define PPS_MASK_GPSB0   16'h78F5
`define PPS_MASK_GPSB1   16'h0141
`define PPS_MASK_GPSCD   16'h0000
`define PPS_MASK_PEREN   16'hFFFF
`define PPS_RST_VALUE    16'h0000

// ============================================================
// Field positions of the select fields
`define PPS_POS_A6   12
`define PPS_POS_A5   10
`define PPS_POS_A4   8
`define PPS_POS_A11  6
`define PPS_POS_A10  4
`define PPS_POS_A9   2
`define PPS_POS_A8   0
`define PPS_POS_B6   13
`define PPS_POS_B5   11
`define PPS_POS_B3   6
`define PPS_POS_B2   4
`define PPS_POS_B1   2
`define PPS_POS_B0   0
`define PPS_POS_B11  8
`define PPS_POS_B10  6
`define PPS_POS_B7   0

// Protection field bits: bit 0 blocks select writes, bit 1 locks the field.
`define PPS_PROT_ON    0
`define PPS_PROT_LOCK  1

`define PPS_NUM_FUNC   27
`define PPS_NUM_PINS   32

`endif

// ==== inc/pps_pkg.sv ====
// Types shared by the pin function selector.
package pps_pkg;

	// ============================================================
	// Peripheral function identifiers, also the bit index into the peripheral buses
	typedef enum logic [4:0] {
		PPS_PWM_FAULT_IN_ZERO = 5'b00000,
		PPS_PWM_FAULT_IN_ONE = 5'b00001,
		PPS_PWM_FAULT_IN_TWO = 5'b00010,
		PPS_PWM_FAULT_IN_THREE = 5'b00011,
		PPS_TMR0   = 5'b00100,
		PPS_TMR1   = 5'b00101,
		PPS_TMR2   = 5'b00110,
		PPS_TMR3   = 5'b00111,
		PPS_PWM_OUTPUT_FOUR   = 5'b01000,
		PPS_PWM_OUTPUT_FIVE   = 5'b01001,
		PPS_CMPBI2 = 5'b01010,
		PPS_CMPAI2 = 5'b01011,
		PPS_COMPARATOR_B_IN_ONE = 5'b01100,
		PPS_COMPARATOR_A_IN_ONE = 5'b01101,
		PPS_COMPARATOR_B_OUTPUT  = 5'b01110,
		PPS_COMPARATOR_A_OUTPUT  = 5'b01111,
		PPS_SRX    = 5'b10000,
		PPS_STX    = 5'b10001,
		PPS_SDA    = 5'b10010,
		PPS_SCL    = 5'b10011,
		PPS_XCLK   = 5'b10100,
		PPS_MOSI   = 5'b10101,
		PPS_MISO   = 5'b10110,
		PPS_SSEL   = 5'b10111,
		PPS_SCLK   = 5'b11000,
		PPS_PWM_PAIR_ONE_SOURCE  = 5'b11001,
		PPS_PWM_PAIR_ZERO_SOURCE  = 5'b11010,
		PPS_NONE   = 5'b11111
	} pps_func_t;

endpackage

// ==== verification/pps_far_model.sv ====
// Model of the on-chip peripherals and the pads beyond the pin function selector.
`timescale 1ns/100ps

module pps_far_model (
	input  wire logic        pclk,
	input  wire logic        load,
	input  wire logic [85:0] stim,
	input  wire logic [15:0] pad_a_o,
	input  wire logic [15:0] pad_b_o,
	input  wire logic [15:0] pad_a_oe_n,
	input  wire logic [15:0] pad_b_oe_n,
	output logic      [26:0] periph_out,
	output logic      [26:0] periph_drive,
	output logic      [15:0] pad_a_i,
	output logic      [15:0] pad_b_i
);
	logic [85:0] state_r = '0;
	logic [31:0] ext;

	// ============================================================
	// Peripheral levels and the outside world change only after a clock edge.
	always @(posedge pclk) begin
		if (load) begin
			state_r <= stim;
		end
	end
	assign {periph_out, periph_drive, ext} = state_r;

	// ============================================================
	// A pad the block drives shows the block's level, otherwise the outside world's.
	assign pad_a_i = (pad_a_oe_n & ext[15:0]) | (~pad_a_oe_n & pad_a_o);
	assign pad_b_i = (pad_b_oe_n & ext[31:16]) | (~pad_b_oe_n & pad_b_o);
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the pin function selector with a register and pin reference model.
`timescale 1ns/100ps
`include "pps_cfg.svh"

module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, load;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pout, pdrv;
	logic [15:0] port_a_in, port_b_in, pad_a_i, pad_b_i, pad_a_o, pad_b_o, pad_a_oe_n, pad_b_oe_n;
	logic [26:0] periph_out, periph_drive, periph_in;
	logic [85:0] stim;
	logic [15:0] mreg [8];
	logic [32:0] q;
	int          err_total, n_compared;
	// Model order: protection, four select words, port C/D word, two enable words.
	localparam logic [7:0]  idx [8] = '{`PPS_IDX_PROT, `PPS_IDX_GPSA0, `PPS_IDX_GPSA1,
		`PPS_IDX_GPSB0, `PPS_IDX_GPSB1, `PPS_IDX_GPSCD, `PPS_IDX_PEREN_A, `PPS_IDX_PEREN_B};
	localparam logic [15:0] msk [8] = '{16'h0003, 16'h1F00, 16'h005F, 16'h78F5, 16'h0141,
		16'h0000, 16'hFFFF, 16'hFFFF};

	pps_pin_select i_pps_pin_select (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .port_a_out(pout[15:0]),
		.port_a_drive(pdrv[15:0]), .port_b_out(pout[31:16]), .port_b_drive(pdrv[31:16]),
		.port_a_in, .port_b_in, .periph_out, .periph_drive, .periph_in, .pad_a_i, .pad_b_i,
		.pad_a_o, .pad_b_o, .pad_a_oe_n, .pad_b_oe_n);
	pps_far_model i_pps_far_model (.pclk, .load, .stim, .pad_a_o, .pad_b_o, .pad_a_oe_n,
		.pad_b_oe_n, .periph_out, .periph_drive, .pad_a_i, .pad_b_i);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ============================================================
	// Closing report and comparisons.
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic cmp_reg(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t register got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_pins(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] c);
		n_compared++;
		if ((got & c) !== (exp & c)) begin
			err_total++;
			$display("ERROR %0t pins got %h expected %h", $time, got & c, exp & c);
		end
	endtask

	// ============================================================
	// Bus cycles; index -1 stands for an unmapped word.
	task automatic apb(input logic w, input int r, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= (r < 0) ? 12'h040 : {2'b00, idx[r], 2'b00};
		pwdata <= {16'hFFFF, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			$display("ERROR %0t bus answer missing", $time);
			end_of_test();
		end
	endtask

	task automatic wr(input int r, input logic [15:0] d);
		apb(1'b1, r, d);
		cmp_reg({q[32], 32'h0}, {r < 0, 32'h0});
		if (r >= 0 && ((r == 0) ? !mreg[0][1] : !mreg[0][0])) mreg[r] = d & msk[r];
	endtask

	task automatic rd(input int r);
		apb(1'b0, r, 16'h0000);
		cmp_reg(q, (r < 0) ? {1'b1, 32'h0} : {17'h0, mreg[r]});
	endtask

	task automatic rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		cmp_pins({pad_b_oe_n, pad_a_oe_n}, 32'hFFFFFFFF, 32'hFFFFFFFF);
		presetn <= 1'b1;
		foreach (mreg[i]) mreg[i] = 16'h0000;
	endtask

	// ============================================================
	// Pin reference model: function of a pin from its select field, 31 meaning none.
	function automatic int pk(input logic [1:0] c, input int x, input int y, input int z);
		return (c == 2'h0) ? x : (c == 2'h1) ? y : (c == 2'h2) ? z : 31;
	endfunction

	function automatic int fs(input int p);
		case (p)
			4: return pk(mreg[1][9:8], 8, 1, 6);
			5: return pk(mreg[1][11:10], 9, 2, 7);
			6: return pk({1'b0, mreg[1][12]}, 0, 4, 31);
			8: return pk(mreg[2][1:0], 1, 6, 13);
			9: return pk(mreg[2][3:2], 2, 7, 12);
			10: return pk({1'b0, mreg[2][4]}, 11, 31, 31);
			11: return pk({1'b0, mreg[2][6]}, 10, 31, 31);
			16: return pk({1'b0, mreg[3][0]}, 24, 19, 31);
			17: return pk({1'b0, mreg[3][2]}, 23, 18, 31);
			18: return pk(mreg[3][5:4], 22, 6, 26);
			19: return pk(mreg[3][7:6], 21, 7, 25);
			21: return pk(mreg[3][12:11], 5, 3, 20);
			22: return pk(mreg[3][14:13], 16, 18, 20);
			23: return pk({1'b0, mreg[4][0]}, 17, 19, 31);
			26: return pk({1'b0, mreg[4][6]}, 15, 31, 31);
			27: return pk({1'b0, mreg[4][8]}, 14, 31, 31);
			default: return 31;
		endcase
	endfunction

	// New random levels everywhere, then long enough for the two-stage switch and the
	// three-edge input path to settle.
	task automatic shake_and_check();
		logic [31:0] pen, pi, eo, eoe, cport;
		logic [26:0] ein;
		int f;
		@(posedge pclk);
		pout <= $urandom;
		pdrv <= $urandom;
		stim <= {22'($urandom), $urandom, $urandom};
		load <= 1'b1;
		@(posedge pclk);
		load <= 1'b0;
		repeat (10) @(posedge pclk);
		pen = {mreg[7], mreg[6]};
		pi = {pad_b_i, pad_a_i};
		ein = '0;
		eo = '0;
		eoe = '1;
		cport = '0;
		for (int p = 0; p < 32; p++) begin
			f = fs(p);
			if (!pen[p]) begin
				eo[p] = pout[p];
				eoe[p] = ~pdrv[p];
				cport[p] = 1'b1;
			end else if (f != 31) begin
				eo[p] = periph_out[f];
				eoe[p] = ~periph_drive[f];
				ein[f] = ein[f] | pi[p];
			end
		end
		cmp_pins({pad_b_oe_n, pad_a_oe_n}, eoe, 32'hFFFFFFFF);
		cmp_pins({pad_b_o, pad_a_o}, eo, ~eoe);
		cmp_pins({5'b0, periph_in}, {5'b0, ein}, 32'hFFFFFFFF);
		cmp_pins({port_b_in, port_a_in}, pi, cport);
	endtask

	// ============================================================
	// Main sequence.
	initial begin
		void'($urandom(92841));
		{presetn, psel, penable, pwrite, load} = '0;
		{paddr, pwdata, pout, pdrv, stim} = '0;
		err_total = 0;
		n_compared = 0;
		rst();
		for (int r = 0; r < 8; r++) rd(r);
		shake_and_check();
		$display("reset values done");
		wr(-1, 16'hFFFF);
		rd(-1);
		$display("unmapped access done");
		// Reserved bits are set on purpose here to see them read back as zero.
		for (int r = 1; r < 8; r++) begin
			wr(r, 16'($urandom));
			rd(r);
		end
		$display("register access done");
		// Software normally enables one pin per function; repeats here exercise fan-out.
		for (int n = 0; n < 44; n++) begin
			for (int r = 1; r < 5; r++) wr(r, (n < 4) ? 16'(16'h5555 * n) : 16'($urandom));
			wr(6, 16'($urandom));
			wr(7, 16'($urandom));
			shake_and_check();
		end
		$display("function routing done");
		wr(0, 16'h0001);
		wr(1, 16'h1F00);
		wr(6, 16'h1234);
		rd(1);
		rd(6);
		shake_and_check();
		wr(0, 16'h0000);
		wr(1, 16'h0A00);
		rd(1);
		wr(0, 16'h0003);
		wr(0, 16'h0000);
		rd(0);
		wr(3, 16'h78F5);
		rd(3);
		rst();
		for (int r = 0; r < 8; r++) rd(r);
		wr(0, 16'h0002);
		wr(0, 16'h0001);
		rd(0);
		wr(2, 16'h005F);
		rd(2);
		shake_and_check();
		$display("protection done");
		end_of_test();
	end
endmodule
